// ### pkg/flash_host_pkg.sv
// Shared constants and types for the parallel flash host controller
package flash_host_pkg;

	// Bus widths
	localparam int ADDR_W = 18;
	localparam int DATA_W = 8;
	localparam int CNT_W  = 8;

	// Operations the user side may request
	typedef enum logic [2:0] {
		OP_READ,
		OP_PROGRAM,
		OP_SECTOR_ERASE,
		OP_CHIP_ERASE,
		OP_LOCKOUT
	} flash_op_e;

	// Command addresses (only the low twelve bits are decoded by the flash)
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 18'h0_0555;
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 18'h0_0AAA;

	// Command data codes
	localparam logic [DATA_W-1:0] CODE_UNLOCK_A = 8'hAA;
	localparam logic [DATA_W-1:0] CODE_UNLOCK_B = 8'h55;
	localparam logic [DATA_W-1:0] CODE_SETUP    = 8'h80;
	localparam logic [DATA_W-1:0] CODE_PROGRAM  = 8'hA0;
	localparam logic [DATA_W-1:0] CODE_CHIP     = 8'h10;
	localparam logic [DATA_W-1:0] CODE_SECTOR   = 8'h30;
	localparam logic [DATA_W-1:0] CODE_LOCKOUT  = 8'h40;

	// Sequence lengths in bus cycles
	localparam logic [2:0] SEQ_LEN_READ    = 3'h1;
	localparam logic [2:0] SEQ_LEN_PROGRAM = 3'h4;
	localparam logic [2:0] SEQ_LEN_LONG    = 3'h6;

	// Status bit positions during an internal operation
	localparam int TOGGLE_BIT = 6;
	localparam int POLL_BIT   = 7;

	// Clock and times in ns, chip erase in ms
	localparam int CLK_PERIOD_NS   = 5;
	localparam int SYNC_STAGES     = 2;
	localparam int SETUP_NS        = 10;
	localparam int WE_PULSE_NS     = 40;
	localparam int HOLD_NS         = 10;
	localparam int RECOVER_NS      = 20;
	localparam int READ_ACCESS_NS  = 55;
	localparam int RESET_LOW_NS    = 500;
	localparam int RESET_RECOV_NS  = 1000;
	localparam int BYTE_PROG_NS    = 20000;
	localparam int CHIP_ERASE_MS   = 4000;

	// Cycle counts; least times round up
	localparam logic [CNT_W-1:0] SETUP_CYC      = CNT_W'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] WE_PULSE_CYC   = CNT_W'((WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] HOLD_CYC       = CNT_W'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] RECOVER_CYC    = CNT_W'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] READ_CYC       =
		CNT_W'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES + 1);
	localparam logic [CNT_W-1:0] RESET_LOW_CYC  = CNT_W'((RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] RESET_RECOV_CYC= CNT_W'((RESET_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int BYTE_PROG_CYC  = BYTE_PROG_NS / CLK_PERIOD_NS;
	localparam int CHIP_ERASE_CYC = CHIP_ERASE_MS * (1000000 / CLK_PERIOD_NS);

endpackage

// ### core/flash_bus_cycle.sv
// One asynchronous read or write cycle on the flash pins
`timescale 1ns/10ps
module flash_bus_cycle (
	// Clock and reset
	input  wire logic                                clk_sys_i,
	input  wire logic                                rst_i,
	// Request side
	input  wire logic                                start_i,
	input  wire logic                                write_i,
	input  wire logic                                abort_i,
	input  wire logic [flash_host_pkg::ADDR_W-1:0]   addr_i,
	input  wire logic [flash_host_pkg::DATA_W-1:0]   wdata_i,
	output logic                                     done_o,
	output logic      [flash_host_pkg::DATA_W-1:0]   rdata_o,
	// Flash pins
	output logic                                     flash_ce_n_o,
	output logic                                     flash_oe_n_o,
	output logic                                     flash_we_n_o,
	output logic      [flash_host_pkg::ADDR_W-1:0]   address_lines_o,
	output logic      [flash_host_pkg::DATA_W-1:0]   data_lines_o,
	output logic                                     data_lines_oe_o,
	input  wire logic [flash_host_pkg::DATA_W-1:0]   data_lines_i
);

	typedef enum logic [2:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD, CY_RECOVER} cycle_state_e;

	cycle_state_e                          state_reg;
	cycle_state_e                          state_next;
	logic [flash_host_pkg::CNT_W-1:0]      cnt_reg;
	logic [flash_host_pkg::CNT_W-1:0]      cnt_next;
	logic                                  write_reg;
	logic [flash_host_pkg::DATA_W-1:0]     data_meta_reg;
	logic [flash_host_pkg::DATA_W-1:0]     data_sync_reg;
	wire                                   cnt_zero;
	wire  [flash_host_pkg::CNT_W-1:0]      strobe_len;

	assign cnt_zero   = (cnt_reg == '0);
	assign strobe_len = write_reg ? flash_host_pkg::WE_PULSE_CYC : flash_host_pkg::READ_CYC;

	// Phase sequencing; chip select falls first and rises last so the write strobe alone
	// frames the cycle: address taken on its fall, data on its rise
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_zero ? cnt_reg : cnt_reg - 1'b1;
		case (state_reg)
			CY_IDLE: begin
				if (start_i) begin
					state_next = CY_SETUP;
					cnt_next   = flash_host_pkg::SETUP_CYC - 1'b1;
				end
			end
			CY_SETUP: begin
				if (cnt_zero) begin
					state_next = CY_STROBE;
					cnt_next   = strobe_len - 1'b1;
				end
			end
			CY_STROBE: begin
				if (cnt_zero) begin
					state_next = CY_HOLD;
					cnt_next   = flash_host_pkg::HOLD_CYC - 1'b1;
				end
			end
			CY_HOLD: begin
				if (cnt_zero) begin
					state_next = CY_RECOVER;
					cnt_next   = flash_host_pkg::RECOVER_CYC - 1'b1;
				end
			end
			CY_RECOVER: begin
				if (cnt_zero)
					state_next = CY_IDLE;
			end
			default: state_next = CY_IDLE;
		endcase
		if (abort_i)
			state_next = CY_IDLE;
	end

	// State, counter and request capture
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_reg <= CY_IDLE;
			cnt_reg   <= '0;
			write_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			if (state_reg == CY_IDLE && start_i)
				write_reg <= write_i;
		end
	end

	// Pins come straight from flip-flops so no glitch reaches the strobes
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			flash_ce_n_o    <= 1'b1;
			flash_oe_n_o    <= 1'b1;
			flash_we_n_o    <= 1'b1;
			data_lines_oe_o <= 1'b0;
			address_lines_o <= '0;
			data_lines_o    <= '0;
		end else begin
			flash_ce_n_o    <= !(state_next inside {CY_SETUP, CY_STROBE, CY_HOLD});
			flash_we_n_o    <= !(state_next == CY_STROBE && write_reg_next());
			flash_oe_n_o    <= !(state_next == CY_STROBE && !write_reg_next());
			data_lines_oe_o <= (state_next inside {CY_SETUP, CY_STROBE, CY_HOLD}) && write_reg_next();
			if (state_reg == CY_IDLE && start_i) begin
				address_lines_o <= addr_i;
				data_lines_o    <= wdata_i;
			end
		end
	end

	// Write flag as it will stand in the next cycle
	function automatic logic write_reg_next();
		return (state_reg == CY_IDLE) ? write_i : write_reg;
	endfunction

	// Read data pass two flip-flops before use
	always_ff @(posedge clk_sys_i) begin
		data_meta_reg <= data_lines_i;
		data_sync_reg <= data_meta_reg;
	end

	// Sample at the end of the output-enable window; the window covers access time plus sync
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rdata_o <= '0;
			done_o  <= 1'b0;
		end else begin
			done_o <= (state_reg == CY_RECOVER) && cnt_zero && !abort_i;
			if (state_reg == CY_STROBE && cnt_zero && !write_reg)
				rdata_o <= data_sync_reg;
		end
	end

endmodule

// ### core/flash_host_ctrl.sv
// Host-side command sequencer for a 256K x 8 parallel NOR flash
//
// Summary of operation
// - Each command cycle pulses write low with chip select low, output enable high.
// - An operation hit by reset is repeated once reset is high again (after abort only; rst_i drops it).
// - Erased bits read one; erase a block before reprogramming its bytes.
// - Chip erase is a six-cycle sequence of fixed address/data pairs.
// - No new access starts until the end of a program is detected or the poll limit runs out.
// - Unlock prefix AA at 555, 55 at AAA; long commands add 80 and repeat.
// - Final codes: 10 chip, 30 sector, 40 lockout, A0 then address/data.
`timescale 1ns/10ps
module flash_host_ctrl #(
	parameter int unsigned POLL_LIMIT_CYC = flash_host_pkg::CHIP_ERASE_CYC
) (
	// Clock and reset
	input  wire logic                                clk_sys_i,
	input  wire logic                                rst_i,
	// User command port
	input  wire logic                                cmd_valid_i,
	output logic                                     cmd_ready_o,
	input  wire flash_host_pkg::flash_op_e           cmd_op_i,
	input  wire logic [flash_host_pkg::ADDR_W-1:0]   cmd_addr_i,
	input  wire logic [flash_host_pkg::DATA_W-1:0]   cmd_data_i,
	input  wire logic                                boot_override_i,
	input  wire logic                                abort_i,
	// User answer port
	output logic                                     done_o,
	output logic      [flash_host_pkg::DATA_W-1:0]   rdata_o,
	output logic                                     timeout_o,
	// Flash pins
	output logic                                     flash_ce_n_o,
	output logic                                     flash_oe_n_o,
	output logic                                     flash_we_n_o,
	output logic                                     flash_rst_n_o,
	output logic                                     boot_override_o,
	output logic      [flash_host_pkg::ADDR_W-1:0]   address_lines_o,
	output logic      [flash_host_pkg::DATA_W-1:0]   data_lines_o,
	output logic                                     data_lines_oe_o,
	input  wire logic [flash_host_pkg::DATA_W-1:0]   data_lines_i
);

	typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_POLL, ST_POLL_WAIT, ST_RST_LOW, ST_RST_RECOV} host_state_e;

	host_state_e                           state_reg;
	flash_host_pkg::flash_op_e             op_reg;
	logic [flash_host_pkg::ADDR_W-1:0]     addr_reg;
	logic [flash_host_pkg::DATA_W-1:0]     data_reg;
	logic [2:0]                            step_reg;
	logic                                  have_prev_reg;
	logic [flash_host_pkg::DATA_W-1:0]     prev_reg;
	logic                                  pending_reg;
	logic [31:0]                           poll_cnt_reg;
	logic [flash_host_pkg::CNT_W-1:0]      rst_cnt_reg;
	logic                                  cyc_start;
	logic                                  cyc_write;
	logic                                  cyc_done;
	logic [flash_host_pkg::ADDR_W-1:0]     cyc_addr;
	logic [flash_host_pkg::DATA_W-1:0]     cyc_data;
	logic [flash_host_pkg::DATA_W-1:0]     cyc_rdata;
	logic [flash_host_pkg::ADDR_W-1:0]     step_addr;
	logic [flash_host_pkg::DATA_W-1:0]     step_data;
	wire  [2:0]                            seq_len;
	wire                                   last_step;
	wire                                   is_read;
	wire                                   is_long;
	wire                                   toggle_still;
	wire                                   poll_bit_ok;
	wire                                   op_finished;
	wire                                   poll_expired;
	wire                                   rst_cnt_zero;

	// Sequence length per operation
	assign is_read   = (op_reg == flash_host_pkg::OP_READ);
	assign is_long   = (op_reg inside {flash_host_pkg::OP_SECTOR_ERASE, flash_host_pkg::OP_CHIP_ERASE,
	                                   flash_host_pkg::OP_LOCKOUT});
	assign seq_len   = is_read ? flash_host_pkg::SEQ_LEN_READ :
	                   is_long ? flash_host_pkg::SEQ_LEN_LONG : flash_host_pkg::SEQ_LEN_PROGRAM;
	assign last_step = (step_reg == seq_len - 3'h1);

	// Address/data pair for the current step; exact pairs only, so no sequence is ever broken
	always_comb begin
		step_addr = flash_host_pkg::UNLOCK_ADDR_A;
		step_data = flash_host_pkg::CODE_UNLOCK_A;
		case (step_reg)
			3'h0: begin
				if (is_read) begin
					step_addr = addr_reg;
					step_data = '0;
				end
			end
			3'h1: begin
				step_addr = flash_host_pkg::UNLOCK_ADDR_B;
				step_data = flash_host_pkg::CODE_UNLOCK_B;
			end
			3'h2: step_data = is_long ? flash_host_pkg::CODE_SETUP : flash_host_pkg::CODE_PROGRAM;
			3'h3: begin
				if (!is_long) begin
					step_addr = addr_reg;
					step_data = data_reg;
				end
			end
			3'h4: begin
				step_addr = flash_host_pkg::UNLOCK_ADDR_B;
				step_data = flash_host_pkg::CODE_UNLOCK_B;
			end
			3'h5: begin
				case (op_reg)
					flash_host_pkg::OP_CHIP_ERASE:   step_data = flash_host_pkg::CODE_CHIP;
					flash_host_pkg::OP_SECTOR_ERASE: begin
						step_addr = addr_reg;
						step_data = flash_host_pkg::CODE_SECTOR;
					end
					flash_host_pkg::OP_LOCKOUT:      step_data = flash_host_pkg::CODE_LOCKOUT;
					default:                         step_data = flash_host_pkg::CODE_UNLOCK_A;
				endcase
			end
			default: step_data = flash_host_pkg::CODE_UNLOCK_A;
		endcase
	end

	// Bus cycle requests; polls are plain reads at the target address
	assign cyc_start = (state_reg == ST_ISSUE) || (state_reg == ST_POLL);
	assign cyc_write = (state_reg == ST_ISSUE) && !is_read;
	assign cyc_addr  = (state_reg == ST_POLL) ? addr_reg : step_addr;
	assign cyc_data  = step_data;

	// End of internal operation: bit six stops toggling, and for a program bit seven is true data
	assign toggle_still = (cyc_rdata[flash_host_pkg::TOGGLE_BIT] == prev_reg[flash_host_pkg::TOGGLE_BIT]);
	assign poll_bit_ok  = (op_reg != flash_host_pkg::OP_PROGRAM) ||
	                      (cyc_rdata[flash_host_pkg::POLL_BIT] == data_reg[flash_host_pkg::POLL_BIT]);
	assign op_finished  = have_prev_reg && toggle_still && poll_bit_ok;
	assign poll_expired = (poll_cnt_reg >= POLL_LIMIT_CYC);
	assign rst_cnt_zero = (rst_cnt_reg == '0);
	assign cmd_ready_o  = (state_reg == ST_IDLE) && !abort_i;

	// Main sequencer
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_reg     <= ST_RST_LOW;
			op_reg        <= flash_host_pkg::OP_READ;
			addr_reg      <= '0;
			data_reg      <= '0;
			step_reg      <= '0;
			have_prev_reg <= 1'b0;
			prev_reg      <= '0;
			pending_reg   <= 1'b0;
			poll_cnt_reg  <= '0;
			rst_cnt_reg   <= flash_host_pkg::RESET_LOW_CYC;
			done_o        <= 1'b0;
			timeout_o     <= 1'b0;
			rdata_o       <= '0;
			boot_override_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (!rst_cnt_zero)
				rst_cnt_reg <= rst_cnt_reg - 1'b1;
			if (state_reg inside {ST_POLL, ST_POLL_WAIT})
				poll_cnt_reg <= poll_cnt_reg + 32'h0000_0001;
			case (state_reg)
				ST_IDLE: begin
					if (cmd_valid_i && !abort_i) begin
						op_reg          <= cmd_op_i;
						addr_reg        <= cmd_addr_i;
						data_reg        <= cmd_data_i;
						boot_override_o <= boot_override_i;
						pending_reg     <= 1'b1;
						step_reg        <= '0;
						state_reg       <= ST_ISSUE;
					end
				end
				ST_ISSUE: state_reg <= ST_WAIT;
				ST_WAIT: begin
					if (cyc_done) begin
						if (!last_step) begin
							step_reg  <= step_reg + 3'h1;
							state_reg <= ST_ISSUE;
						end else if (is_read) begin
							rdata_o     <= cyc_rdata;
							done_o      <= 1'b1;
							timeout_o   <= 1'b0;
							pending_reg <= 1'b0;
							state_reg   <= ST_IDLE;
						end else begin
							have_prev_reg <= 1'b0;
							poll_cnt_reg  <= '0;
							state_reg     <= ST_POLL;
						end
					end
				end
				ST_POLL: state_reg <= ST_POLL_WAIT;
				ST_POLL_WAIT: begin
					if (cyc_done) begin
						prev_reg      <= cyc_rdata;
						have_prev_reg <= 1'b1;
						if (op_finished || poll_expired) begin
							rdata_o         <= cyc_rdata;
							done_o          <= 1'b1;
							timeout_o       <= !op_finished;
							pending_reg     <= 1'b0;
							boot_override_o <= 1'b0;
							state_reg       <= ST_IDLE;
						end else
							state_reg <= ST_POLL;
					end
				end
				ST_RST_LOW: begin
					if (rst_cnt_zero) begin
						rst_cnt_reg <= flash_host_pkg::RESET_RECOV_CYC;
						state_reg   <= ST_RST_RECOV;
					end
				end
				ST_RST_RECOV: begin
					// An interrupted operation is started again from its first cycle
					if (rst_cnt_zero) begin
						step_reg  <= '0;
						state_reg <= pending_reg ? ST_ISSUE : ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
			// Abort pulses the flash reset whatever is in flight; override stays with the op
			if (abort_i) begin
				rst_cnt_reg <= flash_host_pkg::RESET_LOW_CYC;
				state_reg   <= ST_RST_LOW;
			end
		end
	end

	// Flash reset is low while held in reset, so the flash ends in standby with select high
	always_ff @(posedge clk_sys_i) begin
		if (rst_i)
			flash_rst_n_o <= 1'b0;
		else
			flash_rst_n_o <= !(state_reg == ST_RST_LOW && !rst_cnt_zero) && !abort_i;
	end

	// Single bus cycle engine drives every pin but reset and override
	flash_bus_cycle u_cycle (
		.clk_sys_i       (clk_sys_i),
		.rst_i           (rst_i),
		.start_i         (cyc_start),
		.write_i         (cyc_write),
		.abort_i         (abort_i),
		.addr_i          (cyc_addr),
		.wdata_i         (cyc_data),
		.done_o          (cyc_done),
		.rdata_o         (cyc_rdata),
		.flash_ce_n_o    (flash_ce_n_o),
		.flash_oe_n_o    (flash_oe_n_o),
		.flash_we_n_o    (flash_we_n_o),
		.address_lines_o (address_lines_o),
		.data_lines_o    (data_lines_o),
		.data_lines_oe_o (data_lines_oe_o),
		.data_lines_i    (data_lines_i)
	);

endmodule

// ### test/flash_model.sv
// Behavioural parallel NOR flash as seen from the host pins
`timescale 1ns/10ps
module flash_model #(
	parameter int PROG_NS  = 2000,
	parameter int ERASE_NS = 3000
) (
	// Flash pins
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic        rst_n_i,
	input  wire logic        hv_i,
	input  wire logic [17:0] addr_i,
	input  wire logic [7:0]  din_i,
	output logic      [7:0]  dout_o
);
	logic [7:0]  mem [logic [17:0]];
	logic [17:0] a    = 18'h0_0000;
	logic [17:0] pa   = 18'h0_0000;
	logic [7:0]  pd   = 8'h00;
	logic        busy = 1'b0;
	logic        tog  = 1'b0;
	logic        lock = 1'b0;
	int          st   = 0;
	int          gen  = 0;
	wire         drv  = !ce_n_i && !oe_n_i && we_n_i && rst_n_i;
	wire  [11:0] lo12 = a[11:0]; // Upper bits ignored on commands

	function automatic logic [17:0] base(input logic [17:0] x);
		if (x < 18'h0_4000) return 18'h0_0000;
		if (x < 18'h0_8000) return {x[17:13], 13'h0};
		if (x < 18'h1_0000) return 18'h0_8000;
		return {x[17:16], 16'h0};
	endfunction
	function automatic logic [7:0] rd(input logic [17:0] x);
		return mem.exists(x) ? mem[x] : 8'hFF; // Erased bits read one
	endfunction
	function automatic logic prot(input logic [17:0] x);
		return lock && !hv_i && base(x) == 18'h0_0000;
	endfunction
	// Keys are gathered first: deleting inside foreach is not portable
	task automatic erase(input logic all, input logic [17:0] x);
		logic [17:0] q[$];
		foreach (mem[k]) if ((all || base(k) == base(x)) && !prot(k)) q.push_back(k);
		foreach (q[i]) mem.delete(q[i]);
	endtask
	// Internal timer; a reset bumps gen so a stale timer cannot end a new run
	task automatic run(input int t);
		busy = 1'b1;
		gen++;
		fork
			begin
				automatic int g = gen;
				#t;
				if (g == gen) busy = 1'b0;
			end
		join_none
	endtask

	// Address at the later falling edge, which is the strobe here
	always @(negedge we_n_i) if (!ce_n_i) a = addr_i;
	// Data at the earlier rising edge; only program and erase commands touch mem
	always @(posedge we_n_i) if (!ce_n_i && rst_n_i && !busy) begin
		case (st)
			0, 3: st = (lo12 == 12'h555 && din_i == 8'hAA) ? st + 1 : 0;
			1, 4: st = (lo12 == 12'hAAA && din_i == 8'h55) ? st + 1 : 0;
			2: st = (lo12 != 12'h555) ? 0 : din_i == 8'hA0 ? 6 : din_i == 8'h80 ? 3 : 0;
			5: begin
				st = 0;
				if (din_i == 8'h30) begin
					erase(1'b0, a);
					run(ERASE_NS);
				end else if (lo12 == 12'h555 && din_i == 8'h10) begin
					erase(1'b1, a);
					run(ERASE_NS);
				end else if (lo12 == 12'h555 && din_i == 8'h40) lock = 1'b1;
			end
			default: begin // Program only clears bits
				st = 0;
				pa = a;
				pd = din_i;
				if (!prot(a)) begin
					mem[a] = rd(a) & din_i;
					run(PROG_NS);
				end
			end
		endcase
	end
	// Each read while busy flips the toggle bit
	always @(negedge oe_n_i) if (busy) tog = ~tog;
	// Reset abandons sequence and operation
	always @(negedge rst_n_i) begin
		st = 0;
		busy = 1'b0;
		gen++;
	end
	// Floating bus shows inverted data so a late sample cannot pass
	assign dout_o = !drv ? ~rd(addr_i) : busy ? {addr_i == pa && ~pd[7], tog, 6'h00} : rd(addr_i);
endmodule

// ### test/flash_host_ctrl_chk.sv
// Pin protocol checker for the flash host controller
`timescale 1ns/10ps
module flash_host_ctrl_chk (
	// Clock and reset
	input wire logic                              clk_sys_i,
	input wire logic                              rst_i,
	// Watched outputs
	input wire logic                              cmd_ready_o,
	input wire logic                              done_o,
	input wire logic                              flash_ce_n_o,
	input wire logic                              flash_oe_n_o,
	input wire logic                              flash_we_n_o,
	input wire logic                              flash_rst_n_o,
	input wire logic                              data_lines_oe_o,
	input wire logic [flash_host_pkg::ADDR_W-1:0] address_lines_o,
	input wire logic [flash_host_pkg::DATA_W-1:0] data_lines_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	property p_wr_ctl; !flash_we_n_o |-> flash_oe_n_o && !flash_ce_n_o && data_lines_oe_o; endproperty
	a_wr_ctl: assert property (p_wr_ctl) else $error("write strobe without proper select");
	property p_rd_ctl; !flash_oe_n_o |-> !flash_ce_n_o && flash_we_n_o && !data_lines_oe_o; endproperty
	a_rd_ctl: assert property (p_rd_ctl) else $error("read with bus contention");
	property p_we_setup; $fell(flash_we_n_o) |-> $past(flash_ce_n_o, 2) == 1'b0; endproperty
	a_we_setup: assert property (p_we_setup) else $error("strobe fell too soon after select");
	property p_we_width; $fell(flash_we_n_o) |-> !flash_we_n_o [*8] ##1 flash_we_n_o; endproperty
	a_we_width: assert property (p_we_width) else $error("write pulse width wrong");
	property p_stable; !flash_we_n_o && $past(flash_we_n_o) == 1'b0 |-> $stable(address_lines_o) && $stable(data_lines_o); endproperty
	a_stable: assert property (p_stable) else $error("address or data moved in pulse");
	property p_we_rise; $rose(flash_we_n_o) |-> !flash_ce_n_o && data_lines_oe_o && $stable(data_lines_o); endproperty
	a_we_rise: assert property (p_we_rise) else $error("data gone at strobe rise");
	property p_rst_flash; $fell(rst_i) |-> !flash_rst_n_o [*8]; endproperty
	a_rst_flash: assert property (p_rst_flash) else $error("flash reset not pulsed");
	property p_rst_quiet; !flash_rst_n_o |-> flash_we_n_o && flash_oe_n_o; endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("access during flash reset");
	property p_idle; cmd_ready_o |-> flash_ce_n_o && flash_we_n_o && flash_oe_n_o; endproperty
	a_idle: assert property (p_idle) else $error("ready while flash busy");
	property p_done; done_o |=> !done_o; endproperty
	a_done: assert property (p_done) else $error("done longer than one cycle");
endmodule
bind flash_host_ctrl flash_host_ctrl_chk u_flash_host_ctrl_chk (.clk_sys_i, .rst_i, .cmd_ready_o, .done_o,
	.flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_rst_n_o, .data_lines_oe_o, .address_lines_o, .data_lines_o);

// ### test/flash_host_ctrl_test.sv
// Self-checking bench: host controller against a behavioural flash
`timescale 1ns/10ps
module flash_host_ctrl_test;
	logic                      clk_sys_i = 1'b0;
	logic                      rst_i = 1'b1;
	logic                      cmd_valid_i = 1'b0;
	logic                      boot_override_i = 1'b0;
	logic                      abort_i = 1'b0;
	flash_host_pkg::flash_op_e cmd_op_i = flash_host_pkg::OP_READ;
	logic [17:0]               cmd_addr_i = 18'h0_0000;
	logic [7:0]                cmd_data_i = 8'h00;
	logic                      cmd_ready_o, done_o, timeout_o, ce_n, oe_n, we_n, frst_n, hv, doe;
	logic [17:0]               addr, x;
	logic [7:0]                rdata_o, dout, din, dm, d, d2;
	logic [8:0]                notes[$];
	logic [8:0]                nt;
	int                        failures = 0;
	int                        n_tests = 0;

	initial forever #2.5 clk_sys_i = ~clk_sys_i;
	flash_host_ctrl #(.POLL_LIMIT_CYC(20000)) u_flash_host_ctrl (.clk_sys_i, .rst_i, .cmd_valid_i, .cmd_ready_o,
		.cmd_op_i, .cmd_addr_i, .cmd_data_i, .boot_override_i, .abort_i, .done_o, .rdata_o, .timeout_o,
		.flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_rst_n_o(frst_n),
		.boot_override_o(hv), .address_lines_o(addr), .data_lines_o(dout), .data_lines_oe_o(doe), .data_lines_i(din));
	flash_model u_flash_model (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .rst_n_i(frst_n), .hv_i(hv),
		.addr_i(addr), .din_i(dout), .dout_o(dm));
	// Wire level: host drives while writing, the flash otherwise
	assign din = doe ? dout : dm;

	task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wait_ready;
		int n;
		n = 0;
		while (cmd_ready_o !== 1'b1 && n < 40000) begin
			@(negedge clk_sys_i);
			n++;
		end
		if (n == 40000) check("ready", 8'h00, 8'h01);
	endtask
	// Bit 8 of a note marks a byte that must match
	task automatic op(input flash_host_pkg::flash_op_e o, input logic [17:0] a, input logic [7:0] v, input logic [8:0] e);
		wait_ready();
		notes.push_back(e);
		cmd_op_i = o;
		cmd_addr_i = a;
		cmd_data_i = v;
		cmd_valid_i = 1'b1;
		@(negedge clk_sys_i);
		cmd_valid_i = 1'b0;
		@(negedge clk_sys_i);
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Each answer takes the oldest note off the queue; sampled mid-cycle, clear of the launching edge
	always @(negedge clk_sys_i) if (done_o === 1'b1) begin
		check("timeout", {7'h00, timeout_o}, 8'h00);
		if (notes.size() == 0) check("note", 8'h01, 8'h00);
		else begin
			nt = notes.pop_front();
			if (nt[8]) check("rdata", rdata_o, nt[7:0]);
		end
	end
	// Watchdog: about ten times the expected run length
	initial begin
		#300000;
		failures++;
		conclude();
	end
	initial begin
		void'($urandom(32'h2a67_af2b));
		repeat (8) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		rst_i = 1'b0;
		x = {2'h1, 16'($urandom)};
		d = 8'($urandom);
		// Bit seven clear: reprogramming an unerased byte must not leave bit seven unreachable by the poll
		d2 = 8'($urandom) & 8'h7F;
		op(flash_host_pkg::OP_READ, x, 8'h00, {1'b1, 8'hFF});
		op(flash_host_pkg::OP_PROGRAM, x, d, {1'b1, d});
		op(flash_host_pkg::OP_PROGRAM, x, d2, {1'b1, d & d2});
		op(flash_host_pkg::OP_READ, x, 8'h00, {1'b1, d & d2});
		$display("test program done");
		op(flash_host_pkg::OP_PROGRAM, 18'h0_0555, d, {1'b1, d});
		op(flash_host_pkg::OP_SECTOR_ERASE, x, 8'h00, {1'b1, 8'hFF});
		op(flash_host_pkg::OP_READ, 18'h0_0555, 8'h00, {1'b1, d});
		$display("test sector erase done");
		op(flash_host_pkg::OP_LOCKOUT, 18'h0_0555, 8'h00, {1'b1, d});
		op(flash_host_pkg::OP_PROGRAM, 18'h0_0100, d2 | 8'h80, {1'b1, 8'hFF});
		boot_override_i = 1'b1;
		op(flash_host_pkg::OP_PROGRAM, 18'h0_0100, d2 | 8'h80, {1'b1, d2 | 8'h80});
		boot_override_i = 1'b0;
		op(flash_host_pkg::OP_SECTOR_ERASE, 18'h0_0100, 8'h00, {1'b1, d2 | 8'h80});
		$display("test lockout done");
		op(flash_host_pkg::OP_PROGRAM, x, d, {1'b1, d});
		op(flash_host_pkg::OP_CHIP_ERASE, x, 8'h00, {1'b1, 8'hFF});
		op(flash_host_pkg::OP_READ, 18'h0_0555, 8'h00, {1'b1, d});
		$display("test chip erase done");
		fork
			op(flash_host_pkg::OP_PROGRAM, x, d2, {1'b1, d2});
			begin
				repeat (150) @(negedge clk_sys_i);
				abort_i = 1'b1;
				@(negedge clk_sys_i);
				abort_i = 1'b0;
			end
		join
		op(flash_host_pkg::OP_READ, x, 8'h00, {1'b1, d2});
		wait_ready();
		repeat (4) @(negedge clk_sys_i);
		check("pending", 8'(notes.size()), 8'h00);
		$display("test abort done");
		conclude();
	end
endmodule
